// ---- rtl/sesc_regs.vh ----
// Register map, field positions and timing constants of the switch event block
`ifndef SESC_REGS_VH
`define SESC_REGS_VH
`define SESC_CLK_HZ        10000000
`define SESC_TICK_HZ       8192
`define SESC_SW_LEAD_US    62500
`define SESC_SAMPLE_US     31250
`define SESC_PULSE_CYCLES  8'h10
`define SESC_OFF_CTRL      5'h00
`define SESC_OFF_STATUS    5'h04
`define SESC_OFF_MASK      5'h08
`define SESC_OFF_CAPT      5'h0c
`define SESC_OFF_TIME      5'h10
`define SESC_CTRL_W        13
`define SESC_CTRL_RST      13'h0000
`define SESC_C_STOP        0
`define SESC_C_FUNC_LO     1
`define SESC_C_FUNC_HI     2
`define SESC_C_SEL         3
`define SESC_C_POL         4
`define SESC_C_PSTOP       5
`define SESC_C_TSIE        6
`define SESC_C_ILP         7
`define SESC_C_MODE_LO     8
`define SESC_C_MODE_HI     10
`define SESC_C_IRQM_LO     11
`define SESC_C_IRQM_HI     12
`define SESC_S_CAPT        0
`define SESC_S_STOP        8
`define SESC_S_LEVEL       9
`define SESC_S_VALID       10
`define SESC_FUNC_INPUT    2'h3
`define SESC_MODE_LAST     3'h5
`define SESC_IRQM_INT      2'h2
`endif

// ---- rtl/sesc_sampler.v ----
// Event pin synchroniser and periodic or continuous level sampler
`timescale 1ns/100ps
`default_nettype none
module sesc_sampler #(
   parameter SAMPLE_CYCLES = 312500
)(
   input  wire core_clk,
   input  wire rst_n,
   input  wire pin_in,
   input  wire enable,
   input  wire periodic,
   output reg  level,
   output reg  valid
);
   localparam CW = $clog2(SAMPLE_CYCLES + 1);
   localparam integer  LAST_I = SAMPLE_CYCLES - 1;
   localparam [CW-1:0] LAST   = LAST_I[CW-1:0];

   reg          sync1;
   reg          sync2;
   reg          sync3;
   reg [CW-1:0] cnt;
   wire         agree = (sync2 == sync3);
   wire         due   = periodic ? (cnt == LAST) : 1'b1;

   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         sync3 <= 1'b1;
         cnt   <= {CW{1'b0}};
         level <= 1'b1;
         valid <= 1'b0;
      end
      else
      begin
         sync1 <= pin_in;
         sync2 <= sync1;
         sync3 <= sync2;
         // In periodic mode, level is unknown until a full period has run after enable
         if (!enable)
         begin
            cnt   <= {CW{1'b0}};
            valid <= 1'b0;
         end
         else
         begin
            cnt <= (due || !periodic) ? {CW{1'b0}} : cnt + 1'b1;
            // Only a sample instant moves the level
            if (due && agree)
            begin
               level <= sync3;
               valid <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- rtl/sesc_timebase.v ----
// Time counter driven by an 8.192 kHz tick that the stop signal blocks
`timescale 1ns/100ps
`default_nettype none
module sesc_timebase #(
   parameter TICK_CYCLES = 1220,
   parameter TW          = 32
)(
   input  wire          core_clk,
   input  wire          rst_n,
   input  wire          stop,
   input  wire          load,
   input  wire [TW-1:0] load_value,
   output reg  [TW-1:0] time_value
);
   localparam DW = $clog2(TICK_CYCLES + 1);
   localparam integer  LAST_I = TICK_CYCLES - 1;
   localparam [DW-1:0] LAST   = LAST_I[DW-1:0];

   reg [DW-1:0] div;

   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         div        <= {DW{1'b0}};
         time_value <= {TW{1'b0}};
      end
      else
      begin
         // Prescaler also halts, so restart lands within one tick
         if (!stop)
            div <= (div == LAST) ? {DW{1'b0}} : div + 1'b1;
         if (load)
            time_value <= load_value;
         else if (!stop && div == LAST)
            time_value <= time_value + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/sesc_top.v ----
// Switch event stop-watch control: sampler, capture, stop and interrupts
// Notes on behaviour
// - Sampled level invalid until one period after enable when sampling is periodic
// - Pin function 11 makes the pin an input
// - Select bit 1 uses periodic sampling with pull-up
// - Polarity bit 1 makes low the active level
// - Stop-control bit lets active pin stop counting
// - Interrupt enable raises interrupts on the pin only (irq ignores it); pulse when level/pulse bit 0
// - Capture mode 101 captures on every event
// - Interrupt pin mode 10 drives interrupts onto pin
// - Pin change acts only at next sample
// - Sampled inactive-to-active change makes one event
// - Counting halts while sampled pin stays active
// - Event loads capture register and sets flag
// - Capture load pulses the interrupt pin
// - Sampled inactive level releases stop, counting resumes
// - Stop is software stop or active pin
// - Stop blocks 8.192 kHz tick, freezing time
`timescale 1ns/100ps
`default_nettype none
`include "sesc_regs.vh"
module sesc_top #(
   parameter SAMPLE_CYCLES = `SESC_CLK_HZ / 1000000 * `SESC_SAMPLE_US,
   parameter TW            = 32
)(
   input  wire          core_clk,
   input  wire          rst_n,
   input  wire [4:0]    avs_address,
   input  wire          avs_read,
   input  wire          avs_write,
   input  wire [31:0]   avs_writedata,
   input  wire [3:0]    avs_byteenable,
   output reg  [31:0]   avs_readdata,
   output reg           avs_waitrequest,
   input  wire          event_input_pin,
   output reg           event_pin_pullup,
   output reg           counter_stopped,
   output reg           irq,
   output reg           first_irq_pin_n,
   output wire [TW-1:0] time_value
);
   localparam TICK_CYCLES = `SESC_CLK_HZ / `SESC_TICK_HZ;

   reg [`SESC_CTRL_W-1:0] ctrl;
   reg                    second_capture_flag;
   reg                    capt_mask;
   reg [TW-1:0]           second_capture_register;
   reg                    prev_active;
   reg                    prev_valid;
   reg [7:0]              pulse_cnt;
   reg [31:0]             rd_mux;

   wire        samp_level;
   wire        samp_valid;
   wire [1:0]  event_pin_function   = ctrl[`SESC_C_FUNC_HI:`SESC_C_FUNC_LO];
   wire        switch_detect_select = ctrl[`SESC_C_SEL];
   wire        event_pin_polarity   = ctrl[`SESC_C_POL];
   wire        pin_stop_control     = ctrl[`SESC_C_PSTOP];
   wire        timestamp_irq_enable_a = ctrl[`SESC_C_TSIE];
   wire        irq_level_pulse_a    = ctrl[`SESC_C_ILP];
   wire [2:0]  second_capture_mode  = ctrl[`SESC_C_MODE_HI:`SESC_C_MODE_LO];
   wire [1:0]  first_irq_pin_mode   = ctrl[`SESC_C_IRQM_HI:`SESC_C_IRQM_LO];
   wire        soft_stop            = ctrl[`SESC_C_STOP];

   wire pin_input = (event_pin_function == `SESC_FUNC_INPUT);
   // Polarity 1: low is active, polarity 0: high is active
   wire active    = samp_valid & (samp_level ^ event_pin_polarity);
   // Needs a valid previous sample so enabling cannot fake an edge
   wire pin_event = pin_input & samp_valid & prev_valid
                    & active & ~prev_active;
   wire capt_evt  = pin_event
                    & (second_capture_mode == `SESC_MODE_LAST);
   wire next_stop = soft_stop
                    | (pin_stop_control & pin_input & active);
   wire irq_pin_on = timestamp_irq_enable_a
                    & (first_irq_pin_mode == `SESC_IRQM_INT);

   wire        req     = avs_read | avs_write;
   wire        wr_fire = avs_write & ~avs_waitrequest;
   wire [31:0] cur_wr;
   wire        time_load = wr_fire && (avs_address == `SESC_OFF_TIME);
   wire [31:0] time_wide = {{(32-TW){1'b0}}, time_value};

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (be[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   assign cur_wr = avs_writedata;

   wire [31:0] ctrl_merged = merge({{(32-`SESC_CTRL_W){1'b0}}, ctrl}, cur_wr, avs_byteenable);
   wire [31:0] time_merged = merge(time_wide, cur_wr, avs_byteenable);

   sesc_sampler #(
      .SAMPLE_CYCLES (SAMPLE_CYCLES)
   ) u_sampler (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .pin_in   (event_input_pin),
      .enable   (pin_input),
      .periodic (switch_detect_select),
      .level    (samp_level),
      .valid    (samp_valid)
   );

   sesc_timebase #(
      .TICK_CYCLES (TICK_CYCLES),
      .TW          (TW)
   ) u_timebase (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .stop       (counter_stopped),
      .load       (time_load),
      .load_value (time_merged[TW-1:0]),
      .time_value (time_value)
   );

   always @*
   begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         `SESC_OFF_CTRL:
            rd_mux[`SESC_CTRL_W-1:0] = ctrl;
         `SESC_OFF_STATUS:
         begin
            rd_mux[`SESC_S_CAPT]  = second_capture_flag;
            rd_mux[`SESC_S_STOP]  = counter_stopped;
            rd_mux[`SESC_S_LEVEL] = samp_level;
            rd_mux[`SESC_S_VALID] = samp_valid;
         end
         `SESC_OFF_MASK:
            rd_mux[`SESC_S_CAPT] = capt_mask;
         `SESC_OFF_CAPT:
            rd_mux = {{(32-TW){1'b0}}, second_capture_register};
         `SESC_OFF_TIME:
            rd_mux = time_wide;
         default:
            rd_mux = 32'h0000_0000;
      endcase
   end

   // One wait state: data is ready at the edge waitrequest is seen low
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end
      else if (req && avs_waitrequest)
      begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
      end
      else
         avs_waitrequest <= 1'b1;
   end

   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ctrl      <= `SESC_CTRL_RST;
         capt_mask <= 1'b0;
      end
      else if (wr_fire)
      begin
         if (avs_address == `SESC_OFF_CTRL)
            ctrl <= ctrl_merged[`SESC_CTRL_W-1:0];
         if (avs_address == `SESC_OFF_MASK && avs_byteenable[0])
            capt_mask <= cur_wr[`SESC_S_CAPT];
      end
   end

   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         prev_active             <= 1'b0;
         prev_valid              <= 1'b0;
         counter_stopped         <= 1'b0;
         event_pin_pullup        <= 1'b0;
         second_capture_flag     <= 1'b0;
         second_capture_register <= {TW{1'b0}};
      end
      else
      begin
         prev_active      <= active;
         prev_valid       <= samp_valid;
         // Stop follows the sampled level both ways
         counter_stopped  <= next_stop;
         event_pin_pullup <= pin_input & switch_detect_select;
         if (capt_evt)
            second_capture_register <= time_value;
         // A new capture beats a clear in the same cycle
         if (capt_evt)
            second_capture_flag <= 1'b1;
         else if (wr_fire && avs_address == `SESC_OFF_STATUS
                  && avs_byteenable[0] && cur_wr[`SESC_S_CAPT])
            second_capture_flag <= 1'b0;
      end
   end

   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pulse_cnt       <= 8'h00;
         irq             <= 1'b0;
         first_irq_pin_n <= 1'b1;
      end
      else
      begin
         if (capt_evt && irq_pin_on)
            pulse_cnt <= `SESC_PULSE_CYCLES;
         else if (pulse_cnt != 8'h00)
            pulse_cnt <= pulse_cnt - 8'h01;
         irq <= second_capture_flag & capt_mask;
         // Pulse mode ignores the flag; level mode holds until cleared
         first_irq_pin_n <= ~(irq_pin_on & (irq_level_pulse_a ?
                              second_capture_flag : (pulse_cnt != 8'h00)));
      end
   end
endmodule
`default_nettype wire

// ---- test/sesc_props_properties.sv ----
// Port-level concurrent checks for the switch event block
`timescale 1ns/100ps
`default_nettype none
module sesc_props #(
   parameter SAMPLE_CYCLES = 312500,
   parameter TW            = 32
)(
   input wire logic          core_clk,
   input wire logic          rst_n,
   input wire logic [4:0]    avs_address,
   input wire logic          avs_read,
   input wire logic          avs_write,
   input wire logic [31:0]   avs_writedata,
   input wire logic [3:0]    avs_byteenable,
   input wire logic [31:0]   avs_readdata,
   input wire logic          avs_waitrequest,
   input wire logic          event_input_pin,
   input wire logic          event_pin_pullup,
   input wire logic          counter_stopped,
   input wire logic          irq,
   input wire logic          first_irq_pin_n,
   input wire logic [TW-1:0] time_value
);
   wire wr_done = avs_write && !avs_waitrequest;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_wait_bound: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
      else $error("bus request not answered in two cycles");
   chk_rdata_stands: assert property (!avs_waitrequest |=> $stable(avs_readdata))
      else $error("read data changed right after the answer");
   chk_wr_rdata_zero: assert property (wr_done |-> avs_readdata == 32'h0)
      else $error("read data not zero on a write");
   chk_pulse_width: assert property (
      $fell(first_irq_pin_n) |-> (!first_irq_pin_n)[*8] ##1 (!first_irq_pin_n)[*8] ##1 first_irq_pin_n)
      else $error("interrupt pin pulse not sixteen cycles");
   chk_stop_freeze: assert property (counter_stopped && !wr_done |=> $stable(time_value))
      else $error("time moved while stopped");
   chk_time_step: assert property (
      $changed(time_value) && !$past(wr_done) |-> time_value == $past(time_value) + 1'b1 && !$past(counter_stopped))
      else $error("time changed by other than one running tick");
   chk_irq_held: assert property ($fell(irq) |-> $past(wr_done, 2))
      else $error("interrupt dropped without a register write");
   cover property ($fell(first_irq_pin_n));
   cover property ($fell(counter_stopped));
   cover property ($fell(irq));
endmodule
bind sesc_top sesc_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .TW(TW)) u_props (
   .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .event_input_pin(event_input_pin), .event_pin_pullup(event_pin_pullup),
   .counter_stopped(counter_stopped), .irq(irq), .first_irq_pin_n(first_irq_pin_n),
   .time_value(time_value));
`default_nettype wire

// ---- test/sesc_switch.sv ----
// Mechanical switch to ground on the event pin
`timescale 1ns/100ps
`default_nettype none
module sesc_switch (
   input  wire logic core_clk,
   input  wire logic closed,
   input  wire logic pull_en,
   output var  logic pin
);
   logic flt = 1'b0;
   // Open pin with no pull-up floats; toggling stops it passing for a steady level
   always @(posedge core_clk)
      flt <= ~flt;
   assign pin = closed ? 1'b0 : (pull_en ? 1'b1 : flt);
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Bench: bus master, switch stimulus, expected values and verdict
`timescale 1ns/100ps
`default_nettype none
`include "sesc_regs.vh"
module tb;
   localparam int SP = 40;
   logic        core_clk;
   logic        rst_n;
   logic [4:0]  adr;
   logic        rd;
   logic        wr;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        wait_r;
   logic        pin;
   logic        pull_en;
   logic        stopped;
   logic        irq;
   logic        pin_n;
   logic [31:0] tval;
   logic        closed;
   logic [31:0] q;
   logic [31:0] v;
   logic [31:0] capq[$];
   logic [4:0]  rst_adr[5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h14};
   // Sampled level resets to the pulled-up idle level, so status shows it
   logic [31:0] rst_exp[5] = '{32'h0, 32'h200, 32'h0, 32'h0, 32'h0};
   int          n;
   int          bad_count;
   int          tests_run;
   sesc_top #(.SAMPLE_CYCLES(SP), .TW(32)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
      .avs_waitrequest(wait_r), .event_input_pin(pin), .event_pin_pullup(pull_en),
      .counter_stopped(stopped), .irq(irq), .first_irq_pin_n(pin_n), .time_value(tval));
   sesc_switch sw (.core_clk(core_clk), .closed(closed), .pull_en(pull_en), .pin(pin));
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
      adr <= a;
      wr <= w;
      rd <= ~w;
      wdat <= d;
      @(posedge core_clk);
      // Only the watchdog ends a wait that never gets an answer
      while (wait_r !== 1'b0)
         @(posedge core_clk);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic rng(input string s, input logic [31:0] lo, input logic [31:0] hi,
                      input logic [31:0] g);
      tests_run++;
      if ((g >= lo && g <= hi) !== 1'b1)
      begin
         bad_count++;
         $display("BAD %s expected %h..%h seen %h", s, lo, hi, g);
      end
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge core_clk);
   endtask
   // Event lag in cycles, bounded by one sample period plus the synchroniser
   task automatic wait_pulse();
      n = 0;
      while (pin_n !== 1'b0 && n < 200)
      begin
         @(posedge core_clk);
         n++;
      end
      rng("event lag", 1, SP + 10, n);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge core_clk);
      bad_count++;
      $display("BAD watchdog expected finish seen timeout");
      summarize();
   end
   initial
   begin
      {rst_n, adr, rd, wr, wdat, closed} = '0;
      bad_count = 0;
      tests_run = 0;
      v = $urandom(94);
      idle(5);
      rst_n <= 1'b1;
      idle(1);
      bus(5'h14, 1'b1, v);
      for (int i = 0; i < 5; i++)
      begin
         bus(rst_adr[i], 1'b0, 0);
         cmp("reset word", rst_exp[i], q);
      end
      bus(`SESC_OFF_CTRL, 1'b1, 32'h1);
      v = $urandom & 32'h0fffffff;
      bus(`SESC_OFF_TIME, 1'b1, v);
      bus(`SESC_OFF_CAPT, 1'b1, ~v);
      idle(1300);
      bus(`SESC_OFF_TIME, 1'b0, 0);
      cmp("soft stop time", v, q);
      cmp("time port", v, tval);
      bus(`SESC_OFF_CAPT, 1'b0, 0);
      cmp("read-only capture", 0, q);
      // Input, periodic pull-up, active low, pin stop, pulses on the pin, no capture
      bus(`SESC_OFF_CTRL, 1'b1, 32'h107f);
      bus(`SESC_OFF_STATUS, 1'b0, 0);
      cmp("early valid", 0, q & 32'h400);
      cmp("pull-up", 1, 32'(pull_en));
      idle(2 * SP);
      bus(`SESC_OFF_STATUS, 1'b0, 0);
      cmp("open status", 32'h700, q & 32'h701);
      closed <= 1'b1;
      idle(2 * SP);
      bus(`SESC_OFF_STATUS, 1'b0, 0);
      cmp("no capture mode", 32'h500, q & 32'h701);
      cmp("pin idle", 1, 32'(pin_n));
      closed <= 1'b0;
      idle(2 * SP);
      bus(`SESC_OFF_MASK, 1'b1, 1);
      bus(`SESC_OFF_CTRL, 1'b1, 32'h157f);
      capq.push_back(v);
      closed <= 1'b1;
      wait_pulse();
      idle(8);
      cmp("pulse low", 0, 32'(pin_n));
      idle(12);
      cmp("pulse ended", 1, 32'(pin_n));
      bus(`SESC_OFF_CAPT, 1'b0, 0);
      cmp("capture", capq.pop_front(), q);
      bus(`SESC_OFF_STATUS, 1'b0, 0);
      cmp("event status", 32'h501, q & 32'h701);
      cmp("irq", 1, 32'(irq));
      bus(`SESC_OFF_CTRL, 1'b1, 32'h157e);
      idle(1300);
      bus(`SESC_OFF_TIME, 1'b0, 0);
      cmp("pin held time", v, q);
      closed <= 1'b0;
      idle(SP + 10);
      cmp("released", 0, 32'(stopped));
      idle(2500);
      bus(`SESC_OFF_TIME, 1'b0, 0);
      rng("resumed time", v + 1, v + 3, q);
      bus(`SESC_OFF_CTRL, 1'b1, 32'h157f);
      v = $urandom & 32'h0fffffff;
      bus(`SESC_OFF_TIME, 1'b1, v);
      capq.push_back(v);
      closed <= 1'b1;
      wait_pulse();
      bus(`SESC_OFF_CAPT, 1'b0, 0);
      cmp("overwrite", capq.pop_front(), q);
      // The interrupt output follows a register write by one more edge
      bus(`SESC_OFF_MASK, 1'b1, 0);
      idle(1);
      cmp("masked irq", 0, 32'(irq));
      bus(`SESC_OFF_MASK, 1'b1, 1);
      idle(1);
      cmp("unmasked irq", 1, 32'(irq));
      bus(`SESC_OFF_STATUS, 1'b1, 1);
      idle(1);
      cmp("cleared irq", 0, 32'(irq));
      // Active high: the open, pulled-up pin stops counting
      closed <= 1'b0;
      bus(`SESC_OFF_CTRL, 1'b1, 32'h156e);
      idle(SP + 10);
      cmp("active high stop", 1, 32'(stopped));
      closed <= 1'b1;
      bus(`SESC_OFF_CTRL, 1'b1, 32'h1578);
      idle(SP + 10);
      cmp("not input stop", 0, 32'(stopped));
      cmp("not input pull-up", 0, 32'(pull_en));
      summarize();
   end
endmodule
`default_nettype wire
